//--- verilog/overcurrent_select_gang_cdp_regs.sv
// Purpose: Port 7 over-current source select, charging-port detect
//          flags and over-current ganging, behind an APB slave.
// Assumes: Pins are asynchronous; handshake and local over-current
//          inputs come from logic on pclk.
// Notes:   Zero wait states; interrupt on over-current onset and on
//          an invalid gang pin choice while a port is ganged.
module overcurrent_select_gang_cdp_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic overcurrent_sense,
    input wire logic overcurrent_gpio,
    input wire logic [15:0] gang_source_pins,
    input wire logic [5:0] local_overcurrent,
    input wire logic [6:0] cdp_handshake,
    input wire logic [6:0] port_enumerated,
    output hub_cfg_pkg::port_status_t port_status,
    output logic gang_code_invalid,
    output logic irq
);
    logic [7:0] src7_reg;
    logic [7:0] cdp_reg;
    logic [7:0] gang_en_reg;
    logic [7:0] gang_pin_reg;
    logic [7:0] int_status_reg;
    logic [7:0] int_mask_reg;
    logic [17:0] sync_q;

    // Codes 2 and 14 and anything above 15 name no pin
    function automatic logic gang_code_valid(input logic [5:0] code);
        return (code[5:4] == 2'b00) &&
            (code[3:0] != hub_cfg_pkg::GANG_HOLE_A) &&
            (code[3:0] != hub_cfg_pkg::GANG_HOLE_B);
    endfunction

    function automatic logic addr_is(input logic [19:0] a,
                                     input logic [19:0] b);
        return a == b;
    endfunction

    signal_sync2 #(
        .WIDTH(hub_cfg_pkg::SYNC_WIDTH)
    ) pin_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({overcurrent_gpio, overcurrent_sense, gang_source_pins}),
        .q(sync_q)
    );

    wire sense_q = sync_q[hub_cfg_pkg::SYNC_SENSE_BIT];
    wire gpio_q = sync_q[hub_cfg_pkg::SYNC_GPIO_BIT];
    wire [15:0] pins_q = sync_q[15:0];

    // APB decode
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire wr = access && pwrite;
    wire hit_src7 = addr_is(paddr, hub_cfg_pkg::ADDR_SRC7);
    wire hit_cdp = addr_is(paddr, hub_cfg_pkg::ADDR_CDP);
    wire hit_gang_en = addr_is(paddr, hub_cfg_pkg::ADDR_GANG_EN);
    wire hit_gang_pin = addr_is(paddr, hub_cfg_pkg::ADDR_GANG_PIN);
    wire hit_int_status = addr_is(paddr, hub_cfg_pkg::ADDR_INT_STATUS);
    wire hit_int_mask = addr_is(paddr, hub_cfg_pkg::ADDR_INT_MASK);
    wire mapped = hit_src7 || hit_cdp || hit_gang_en || hit_gang_pin ||
        hit_int_status || hit_int_mask;
    wire [7:0] wdata8 = pwdata[7:0];

    wire [7:0] read_byte =
        hit_src7 ? src7_reg :
        hit_cdp ? cdp_reg :
        hit_gang_en ? gang_en_reg :
        hit_gang_pin ? gang_pin_reg :
        hit_int_status ? int_status_reg :
        hit_int_mask ? int_mask_reg : 8'h00;

    // Port 7 source selection
    wire [3:0] src7_code = src7_reg[hub_cfg_pkg::SRC_LSB +: 4];
    logic port7_local;
    logic port7_off;

    always_comb
    begin
        port7_local = 1'b0;
        port7_off = 1'b0;
        case (src7_code)
            hub_cfg_pkg::SRC_DISABLED:
            begin
                port7_off = 1'b1;
            end
            hub_cfg_pkg::SRC_SENSE_PIN:
            begin
                port7_local = sense_q;
            end
            hub_cfg_pkg::SRC_GPIO:
            begin
                port7_local = gpio_q;
            end
            hub_cfg_pkg::SRC_FORCED:
            begin
                port7_local = 1'b1;
            end
            default:
            begin
                // Reserved codes: report no over-current rather than guess
                port7_local = 1'b0;
            end
        endcase
    end

    // Gang routing
    wire [5:0] gang_code = gang_pin_reg[5:0];
    wire gang_valid = gang_code_valid(gang_code);
    wire gang_pin_level = gang_valid ? pins_q[gang_code[3:0]] : 1'b0;
    wire [6:0] gang_en = gang_en_reg[hub_cfg_pkg::GANG_EN_LSB +: 7];
    wire [6:0] local_all = {port7_local, local_overcurrent};
    wire [6:0] oc_next;

    genvar gi;
    generate
        for (gi = 0; gi < hub_cfg_pkg::NUM_PORTS; gi++)
        begin : g_route
            assign oc_next[gi] = gang_en[gi] ? gang_pin_level
                                             : local_all[gi];
        end
    endgenerate

    wire invalid_next = (|gang_en) && !gang_valid;

    // Events: set beats a same-cycle clear everywhere below
    wire [6:0] oc_rise = oc_next & ~port_status.overcurrent;
    wire invalid_rise = invalid_next && !gang_code_invalid;
    wire [7:0] int_events = {invalid_rise, oc_rise};
    wire [7:0] int_clear = (wr && hit_int_status) ? wdata8 : 8'h00;
    wire [7:0] int_status_next =
        (int_status_reg & ~int_clear) | int_events;
    wire [7:0] int_mask_next =
        (wr && hit_int_mask) ? wdata8 : int_mask_reg;
    wire [6:0] cdp_event = cdp_handshake & ~port_enumerated;
    wire [7:0] cdp_base = (wr && hit_cdp) ? wdata8 : cdp_reg;
    wire [7:0] cdp_next = cdp_base | {1'b0, cdp_event};

    // Configuration registers; reserved bits kept as written
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src7_reg <= hub_cfg_pkg::RST_SRC7;
            gang_en_reg <= hub_cfg_pkg::RST_GANG_EN;
            gang_pin_reg <= hub_cfg_pkg::RST_GANG_PIN;
        end
        else
        begin
            if (wr && hit_src7)
                src7_reg <= wdata8;
            if (wr && hit_gang_en)
                gang_en_reg <= wdata8;
            if (wr && hit_gang_pin)
                gang_pin_reg <= wdata8;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cdp_reg <= hub_cfg_pkg::RST_CDP;
            int_status_reg <= hub_cfg_pkg::RST_INT;
            int_mask_reg <= hub_cfg_pkg::RST_INT;
            irq <= 1'b0;
        end
        else
        begin
            cdp_reg <= cdp_next;
            int_status_reg <= int_status_next;
            int_mask_reg <= int_mask_next;
            irq <= |(int_status_next & int_mask_next);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_status <= '0;
            gang_code_invalid <= 1'b0;
        end
        else
        begin
            port_status.overcurrent <= oc_next;
            port_status.port7_disabled <= port7_off;
            gang_code_invalid <= invalid_next;
        end
    end

    // Read data is captured at the end of setup, so it may lag a
    // same-cycle hardware update by one clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= hub_cfg_pkg::RST_RDATA;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup)
                prdata <= {24'h00_0000, read_byte};
        end
    end

    // Checks
    wire src7_write = wr && hit_src7;

    property p_src_disabled;
        @(posedge pclk) disable iff (!presetn)
        (src7_code == hub_cfg_pkg::SRC_DISABLED) && !gang_en[6]
            |=> port_status.port7_disabled &&
                !port_status.overcurrent[6];
    endproperty
    a_src_disabled: assert property (p_src_disabled)
        else $error("Disabled port 7 shows over-current");

    property p_src_sense;
        @(posedge pclk) disable iff (!presetn)
        (src7_code == hub_cfg_pkg::SRC_SENSE_PIN) && !gang_en[6]
            |=> port_status.overcurrent[6] == $past(sense_q);
    endproperty
    a_src_sense: assert property (p_src_sense)
        else $error("Port 7 does not follow the sense pin");

    property p_src_gpio;
        @(posedge pclk) disable iff (!presetn)
        (src7_code == hub_cfg_pkg::SRC_GPIO) && !gang_en[6]
            |=> port_status.overcurrent[6] == $past(gpio_q);
    endproperty
    a_src_gpio: assert property (p_src_gpio)
        else $error("Port 7 does not follow the GPIO pin");

    property p_src_forced;
        @(posedge pclk) disable iff (!presetn)
        (src7_code == hub_cfg_pkg::SRC_FORCED) && !gang_en[6]
            |=> port_status.overcurrent[6] && !port_status.port7_disabled;
    endproperty
    a_src_forced: assert property (p_src_forced)
        else $error("Forced mode does not hold over-current on");

    property p_cdp_set;
        @(posedge pclk) disable iff (!presetn)
        (cdp_event != 7'h00)
            |=> ((cdp_reg[6:0] & $past(cdp_event)) == $past(cdp_event));
    endproperty
    a_cdp_set: assert property (p_cdp_set)
        else $error("Charging-port flag not set by handshake");

    property p_gang_route;
        @(posedge pclk) disable iff (!presetn)
        gang_en[0] |=> port_status.overcurrent[0] == $past(gang_pin_level);
    endproperty
    a_gang_route: assert property (p_gang_route)
        else $error("Ganged port 1 does not follow the gang pin");

    property p_gang_invalid;
        @(posedge pclk) disable iff (!presetn)
        (gang_en != 7'h00) && !gang_code_invalid &&
            (gang_code == {2'b00, hub_cfg_pkg::GANG_HOLE_B})
            |=> gang_code_invalid
                && int_status_reg[hub_cfg_pkg::INT_INVALID_BIT];
    endproperty
    a_gang_invalid: assert property (p_gang_invalid)
        else $error("Invalid gang code not flagged");

    property p_reserved_store;
        @(posedge pclk) disable iff (!presetn)
        src7_write |=> src7_reg == $past(wdata8);
    endproperty
    a_reserved_store: assert property (p_reserved_store)
        else $error("Select register did not keep written byte");

    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("Slave did not answer after one setup cycle");

    c_forced: cover property (@(posedge pclk) disable iff (!presetn)
        src7_code == hub_cfg_pkg::SRC_FORCED ##1 port_status.overcurrent[6]);
    c_gang: cover property (@(posedge pclk) disable iff (!presetn)
        gang_en[0] && gang_pin_level ##1 port_status.overcurrent[0]);
    c_cdp: cover property (@(posedge pclk) disable iff (!presetn)
        cdp_event[6] ##1 cdp_reg[6]);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn)
        !irq ##1 irq);
endmodule

//--- include/hub_cfg_pkg.sv
// Purpose: Shared constants and types for the over-current select,
//          gang and charging-port register block.
// Assumes: APB slave, 32-bit data, one register per aligned word.
// Notes:   Byte address is four times the register index.
package hub_cfg_pkg;
    localparam int NUM_PORTS = 7;
    localparam int GANG_PINS = 16;
    localparam int SYNC_WIDTH = 18;
    localparam int ADDR_W = 20;

    // Register indices; byte addresses are index times four
    localparam logic [15:0] IDX_SRC7 = 16'h3c38;
    localparam logic [15:0] IDX_CDP = 16'h5246;
    localparam logic [15:0] IDX_GANG_EN = 16'h525a;
    localparam logic [15:0] IDX_GANG_PIN = 16'h525b;
    localparam logic [15:0] IDX_INT_STATUS = 16'h5260;
    localparam logic [15:0] IDX_INT_MASK = 16'h5261;

    localparam logic [19:0] ADDR_SRC7 = {2'b00, IDX_SRC7, 2'b00};
    localparam logic [19:0] ADDR_CDP = {2'b00, IDX_CDP, 2'b00};
    localparam logic [19:0] ADDR_GANG_EN = {2'b00, IDX_GANG_EN, 2'b00};
    localparam logic [19:0] ADDR_GANG_PIN = {2'b00, IDX_GANG_PIN, 2'b00};
    localparam logic [19:0] ADDR_INT_STATUS =
        {2'b00, IDX_INT_STATUS, 2'b00};
    localparam logic [19:0] ADDR_INT_MASK = {2'b00, IDX_INT_MASK, 2'b00};

    // Over-current source codes, low nibble of the select register
    localparam logic [3:0] SRC_DISABLED = 4'h0;
    localparam logic [3:0] SRC_SENSE_PIN = 4'h1;
    localparam logic [3:0] SRC_GPIO = 4'h2;
    localparam logic [3:0] SRC_FORCED = 4'hf;

    // Gang pin codes that name no pin
    localparam logic [3:0] GANG_HOLE_A = 4'h2;
    localparam logic [3:0] GANG_HOLE_B = 4'he;

    // Field positions
    localparam int SRC_LSB = 0;
    localparam int GANG_EN_LSB = 1;
    localparam int INT_INVALID_BIT = 7;
    localparam int SYNC_SENSE_BIT = 16;
    localparam int SYNC_GPIO_BIT = 17;

    // Values after reset
    localparam logic [7:0] RST_SRC7 = 8'h00;
    localparam logic [7:0] RST_CDP = 8'h00;
    localparam logic [7:0] RST_GANG_EN = 8'h00;
    localparam logic [7:0] RST_GANG_PIN = 8'h00;
    localparam logic [7:0] RST_INT = 8'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    typedef struct packed {
        logic [NUM_PORTS-1:0] overcurrent;
        logic port7_disabled;
    } port_status_t;
endpackage

//--- verilog/signal_sync2.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are levels; pulses shorter than a clock are lost.
// Notes:   First stage feeds only the second stage.
module signal_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

//--- testbench/ocs_switch_model.sv
// Purpose: Far-side power switches raising over-current flags.
// Assumes: Flags are active-high levels on asynchronous pins.
// Notes:   One pclk of lag, as a slow switch would show.
module pin_switch_model (
    input wire logic pclk,
    input wire logic [17:0] fault,
    output logic overcurrent_sense,
    output logic overcurrent_gpio,
    output logic [15:0] gang_source_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] fault_reg = 18'h0_0000;

    always @(posedge pclk)
    begin
        fault_reg <= fault;
    end
    assign overcurrent_sense = fault_reg[16];
    assign overcurrent_gpio = fault_reg[17];
    assign gang_source_pins = fault_reg[15:0];
endmodule

//--- testbench/tb_overcurrent_select_gang_cdp_regs.sv
// Purpose: Self-checking bench for the select, gang and detect block.
// Assumes: Zero-wait APB slave; pins settle within eight edges.
// Notes:   Reset before each source code; the select is writable at any time.
`define CHECK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module tb_overcurrent_select_gang_cdp_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic sense, gpio, invalid, irq, errv, valid;
    logic [15:0] pins;
    logic [5:0] local_oc;
    logic [6:0] handshake, enumerated;
    logic [17:0] fault;
    hub_cfg_pkg::port_status_t status;
    int bad_count, check_count;
    logic [3:0] src_code [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hf};
    logic [1:0] src_exp [5] = '{2'b00, 2'b01, 2'b10, 2'b00, 2'b11};
    logic [19:0] regs [6] = '{hub_cfg_pkg::ADDR_SRC7,
        hub_cfg_pkg::ADDR_CDP, hub_cfg_pkg::ADDR_GANG_EN,
        hub_cfg_pkg::ADDR_GANG_PIN, hub_cfg_pkg::ADDR_INT_STATUS,
        hub_cfg_pkg::ADDR_INT_MASK};

    overcurrent_select_gang_cdp_regs dut_u (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .overcurrent_sense(sense), .overcurrent_gpio(gpio),
        .gang_source_pins(pins), .local_overcurrent(local_oc),
        .cdp_handshake(handshake), .port_enumerated(enumerated),
        .port_status(status), .gang_code_invalid(invalid), .irq(irq));
    pin_switch_model switch_u (.pclk(pclk), .fault(fault),
        .overcurrent_sense(sense), .overcurrent_gpio(gpio),
        .gang_source_pins(pins));

    task automatic apb(input logic wr, input logic [19:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdv, errv);
    endtask

    task automatic rd(input logic [19:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, rdv, errv);
        `CHECK(rdv, e)
    endtask

    task automatic settle();
        repeat (8) @(posedge pclk);
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        fault <= 18'h0_0000;
        local_oc <= 6'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic summarize();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        summarize();
    end

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 20'h0_0000;
        pwdata = 32'h0000_0000;
        fault = 18'h0_0000;
        local_oc = 6'h00;
        handshake = 7'h00;
        enumerated = 7'h00;
        do_reset();
        foreach (regs[i])
            rd(regs[i], 32'h0000_0000);
        apb(1'b0, 20'h0_0004, 32'h0000_0000, rdv, errv);
        `CHECK(errv, 1'b1)
        `CHECK(rdv, 32'h0000_0000)
        // Each code loaded once after its own reset
        for (int k = 0; k < 5; k++)
        begin
            do_reset();
            wr(hub_cfg_pkg::ADDR_SRC7, {28'h0, src_code[k]});
            fault <= 18'h1_0000;
            settle();
            `CHECK(status.overcurrent[6], src_exp[k][0])
            `CHECK(status.port7_disabled, src_code[k] == 4'h0)
            fault <= 18'h2_0000;
            settle();
            `CHECK(status.overcurrent[6], src_exp[k][1])
        end
        do_reset();
        wr(hub_cfg_pkg::ADDR_SRC7, 32'hffff_fff0);
        rd(hub_cfg_pkg::ADDR_SRC7, 32'h0000_00f0);
        enumerated <= 7'h55;
        handshake <= 7'h7f;
        @(posedge pclk);
        handshake <= 7'h00;
        rd(hub_cfg_pkg::ADDR_CDP, 32'h0000_002a);
        wr(hub_cfg_pkg::ADDR_CDP, 32'h0000_0080);
        rd(hub_cfg_pkg::ADDR_CDP, 32'h0000_0080);
        enumerated <= 7'h00;
        handshake <= 7'h40;
        @(posedge pclk);
        handshake <= 7'h00;
        rd(hub_cfg_pkg::ADDR_CDP, 32'h0000_00c0);
        do_reset();
        wr(hub_cfg_pkg::ADDR_INT_MASK, 32'h0000_0040);
        wr(hub_cfg_pkg::ADDR_SRC7, 32'h0000_0001);
        fault <= 18'h1_0000;
        settle();
        `CHECK(irq, 1'b1)
        rd(hub_cfg_pkg::ADDR_INT_STATUS, 32'h0000_0040);
        wr(hub_cfg_pkg::ADDR_INT_STATUS, 32'h0000_0040);
        settle();
        `CHECK(irq, 1'b0)
        local_oc <= 6'h01;
        settle();
        `CHECK(irq, 1'b0)
        rd(hub_cfg_pkg::ADDR_INT_STATUS, 32'h0000_0001);
        // Local flag high so a dead gang cannot pass for the local one
        wr(hub_cfg_pkg::ADDR_GANG_EN, 32'h0000_0002);
        for (int n = 0; n < 17; n++)
        begin
            valid = (n != 2 && n != 14 && n < 16);
            wr(hub_cfg_pkg::ADDR_GANG_PIN, 32'(n));
            fault <= {2'b00, valid ? 16'h0001 << n : 16'hffff};
            settle();
            `CHECK(status.overcurrent[0], valid)
            `CHECK(invalid, !valid)
        end
        // Every port ganged to one pin, then every port local again
        wr(hub_cfg_pkg::ADDR_GANG_EN, 32'h0000_00fe);
        wr(hub_cfg_pkg::ADDR_GANG_PIN, 32'h0000_0001);
        fault <= 18'h0_0002;
        settle();
        `CHECK(status.overcurrent, 7'h7f)
        wr(hub_cfg_pkg::ADDR_GANG_EN, 32'h0000_0000);
        local_oc <= 6'h2a;
        settle();
        `CHECK(status.overcurrent, 7'h2a)
        do_reset();
        wr(hub_cfg_pkg::ADDR_GANG_EN, 32'h0000_0001);
        wr(hub_cfg_pkg::ADDR_GANG_PIN, 32'h0000_00c2);
        settle();
        `CHECK(invalid, 1'b0)
        rd(hub_cfg_pkg::ADDR_GANG_PIN, 32'h0000_00c2);
        rd(hub_cfg_pkg::ADDR_GANG_EN, 32'h0000_0001);
        summarize();
    end
endmodule
